// ===== shared/fftc_pkg.sv
// fftc_pkg: build options, configuration/status word layouts and field widths
package fftc_pkg;

    // build options of the engine
    localparam int unsigned MAX_NFFT   = 10;   // largest size is 1 << MAX_NFFT, valid 3..16
    localparam int unsigned MIN_NFFT   = 3;
    localparam bit          HAS_NFFT   = 1'b1; // run-time size selection enabled
    localparam bit          FLOAT_DATA = 1'b0; // float samples force 32-bit components
    localparam int unsigned FLOAT_W    = 32;
    localparam int unsigned FIXED_IN_W  = 16;
    localparam int unsigned FIXED_OUT_W = 16;
    localparam int unsigned CHANNELS   = 1;    // 1..12

    // round a width up to whole bytes
    function automatic int unsigned pad8(input int unsigned w);
        pad8 = ((w + 7) / 8) * 8;
    endfunction

    localparam int unsigned IN_W    = FLOAT_DATA ? FLOAT_W : FIXED_IN_W;
    localparam int unsigned OUT_W   = FLOAT_DATA ? FLOAT_W : FIXED_OUT_W;
    localparam int unsigned IN_PAD  = pad8(IN_W);
    localparam int unsigned OUT_PAD = pad8(OUT_W);

    // configuration word: size log2 in the low bits, direction, then schedule
    localparam int unsigned NFFT_W      = 5;
    localparam int unsigned CFG_NFFT_LSB = 0;
    localparam int unsigned CFG_DIR_BIT  = 8;
    localparam int unsigned SCH_W        = 2 * ((MAX_NFFT + 1) / 2);
    localparam int unsigned CFG_SCH_LSB  = 9;
    localparam int unsigned CFG_W        = pad8(CFG_SCH_LSB + SCH_W);
    localparam logic        DIR_FORWARD  = 1'b1;
    localparam logic        DIR_INVERSE  = 1'b0;

    // status word: overflow flag and block exponent
    localparam int unsigned EXP_W        = 5;
    localparam int unsigned STAT_OVF_BIT = 0;
    localparam int unsigned STAT_EXP_LSB = 1;
    localparam int unsigned STAT_W       = 8;

    // counters
    localparam int unsigned CH_W  = 4;
    localparam int unsigned CNT_W = 21;

    typedef enum logic [1:0] {
        FFTC_IDLE  = 2'b00,
        FFTC_LOAD  = 2'b01,
        FFTC_DRAIN = 2'b10,
        FFTC_STAT  = 2'b11
    } fftc_state_t;

endpackage : fftc_pkg

// ===== rtl/fftc_pad.sv
// fftc_pad: sign-extends one sample component into a byte-multiple field
`timescale 1ns/100ps
`default_nettype none
module fftc_pad #(
    parameter int unsigned W  = 16,
    parameter int unsigned PW = 16
) (
    // raw component
    input  wire logic [W-1:0]  raw,
    // byte-padded component
    output logic      [PW-1:0] padded
);
    // pad bits copy the sign so the widened field keeps its value
    generate
        if (PW > W) begin : g_ext
            assign padded = {{(PW - W){raw[W-1]}}, raw};
        end else begin : g_same
            assign padded = raw;
        end
    endgenerate
endmodule // fftc_pad
`default_nettype wire

// ===== rtl/fftc_wrap.sv
// fftc_wrap: run-time configuration, status and stream framing around a transform engine
`timescale 1ns/100ps
`default_nettype none
// How it works
// (RULE1) the size field holds log2 of the point count, so 9 asks for 512 points.
// (RULE2) the requester never asks for a size above the built maximum.
// (RULE3) the size field is used only when run-time sizing is built in, else the built maximum.
// (RULE4) the direction bit is 1 for forward and 0 for inverse.
// (RULE5) the schedule field is handed to the engine for the transform that follows.
// (RULE6) configuration and status travel on their own ports, apart from the sample ports.
// (RULE7) the status word carries a flag set when any overflow hit the finished transform.
// (RULE8) the status word carries the block exponent of the finished transform.
// (RULE9) the consumer checks the overflow flag after every transform.
// (RULE10) sample in and result out ports are AXI4-Stream.
// (RULE11) floating-point components are exactly 32 bits wide.
// (RULE12) each component sits in a field widened to the next multiple of 8 bits.
// (RULE13) multichannel samples are interleaved by channel, channel index running fastest.
// (RULE14) a build option says whether the size may change at run time.
// (RULE15) the largest size is 1 << MAX_NFFT, with MAX_NFFT from 3 to 16.
// (RULE16) one configuration word precedes each frame and one status word follows it.
module fftc_wrap (
    // clock, reset, enable
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          ce,
    // configuration stream
    input  wire logic                          s_axis_config_tvalid,
    output logic                               s_axis_config_tready,
    input  wire logic [fftc_pkg::CFG_W-1:0]    s_axis_config_tdata,
    // sample input stream
    input  wire logic                          s_axis_data_tvalid,
    output logic                               s_axis_data_tready,
    input  wire logic [2*fftc_pkg::IN_PAD-1:0] s_axis_data_tdata,
    input  wire logic                          s_axis_data_tlast,
    // result output stream
    output logic                               m_axis_data_tvalid,
    input  wire logic                          m_axis_data_tready,
    output logic [2*fftc_pkg::OUT_PAD-1:0]     m_axis_data_tdata,
    output logic [fftc_pkg::CH_W-1:0]          m_axis_data_tuser,
    output logic                               m_axis_data_tlast,
    // status stream
    output logic                               m_axis_status_tvalid,
    input  wire logic                          m_axis_status_tready,
    output logic [fftc_pkg::STAT_W-1:0]        m_axis_status_tdata,
    // engine controls
    output logic                               eng_start,
    output logic [fftc_pkg::NFFT_W-1:0]        eng_size_log2,
    output logic                               eng_forward,
    output logic [fftc_pkg::SCH_W-1:0]         eng_sched,
    // engine sample input
    output logic                               eng_in_valid,
    input  wire logic                          eng_in_ready,
    output logic [fftc_pkg::IN_W-1:0]          eng_in_re,   // see RULE11
    output logic [fftc_pkg::IN_W-1:0]          eng_in_im,
    // engine result output
    input  wire logic                          eng_out_valid,
    output logic                               eng_out_ready,
    input  wire logic [fftc_pkg::OUT_W-1:0]    eng_out_re,
    input  wire logic [fftc_pkg::OUT_W-1:0]    eng_out_im,
    input  wire logic                          eng_out_overflow,
    input  wire logic [fftc_pkg::EXP_W-1:0]    eng_blk_exp,
    // framing events
    output logic                               ev_frame_started,
    output logic                               ev_tlast_unexpected,
    output logic                               ev_tlast_missing
);
    localparam int unsigned CW = fftc_pkg::CNT_W;
    localparam logic [fftc_pkg::CH_W-1:0] CH_LAST = fftc_pkg::CH_W'(fftc_pkg::CHANNELS - 1);
    localparam logic [fftc_pkg::NFFT_W-1:0] NFFT_MAX =
        fftc_pkg::NFFT_W'(fftc_pkg::MAX_NFFT);                                    // see RULE15

    // size actually used: requested field only when run-time sizing is built in
    function automatic logic [fftc_pkg::NFFT_W-1:0] eff_size(
        input logic [fftc_pkg::CFG_W-1:0] cfg);
        eff_size = fftc_pkg::HAS_NFFT ? cfg[fftc_pkg::CFG_NFFT_LSB +: fftc_pkg::NFFT_W]
                                      : NFFT_MAX;                           // see RULE14
    endfunction

    fftc_pkg::fftc_state_t state_q;
    logic [CW-1:0]                 frame_last_q;   // beats per frame minus one
    logic [CW-1:0]                 in_cnt_q;
    logic [CW-1:0]                 out_cnt_q;
    logic [fftc_pkg::CH_W-1:0]     out_ch_q;
    logic                          ovf_q;
    logic [fftc_pkg::EXP_W-1:0]    exp_q;
    logic [fftc_pkg::STAT_W-1:0]   stat_q;
    logic [2*fftc_pkg::OUT_PAD-1:0] out_pad;

    wire cfg_hs   = s_axis_config_tvalid && s_axis_config_tready;
    wire in_hs    = s_axis_data_tvalid && s_axis_data_tready;
    wire eout_hs  = eng_out_valid && eng_out_ready;
    wire mout_hs  = m_axis_data_tvalid && m_axis_data_tready && ce;
    wire in_final = (in_cnt_q == frame_last_q);
    wire out_final = (out_cnt_q == frame_last_q);

    // handshakes: config only between frames, samples only while loading
    assign s_axis_config_tready = ce && (state_q == fftc_pkg::FFTC_IDLE);     // see RULE16
    assign s_axis_data_tready   = ce && (state_q == fftc_pkg::FFTC_LOAD)
                                  && (!eng_in_valid || eng_in_ready);
    assign eng_out_ready        = ce && (state_q != fftc_pkg::FFTC_IDLE)
                                  && (state_q != fftc_pkg::FFTC_STAT)
                                  && (!m_axis_data_tvalid || m_axis_data_tready);
    assign m_axis_status_tvalid = (state_q == fftc_pkg::FFTC_STAT);          // see RULE6
    assign m_axis_status_tdata  = stat_q;

    // frame sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= fftc_pkg::FFTC_IDLE;
        end else if (ce) begin
            case (state_q)
                fftc_pkg::FFTC_IDLE: begin
                    if (cfg_hs) state_q <= fftc_pkg::FFTC_LOAD;
                end
                fftc_pkg::FFTC_LOAD: begin
                    if (in_hs && in_final) state_q <= fftc_pkg::FFTC_DRAIN;
                end
                fftc_pkg::FFTC_DRAIN: begin
                    if (mout_hs && m_axis_data_tlast) state_q <= fftc_pkg::FFTC_STAT; // see RULE16
                end
                fftc_pkg::FFTC_STAT: begin
                    if (m_axis_status_tready) state_q <= fftc_pkg::FFTC_IDLE;
                end
                default: state_q <= fftc_pkg::FFTC_IDLE;
            endcase
        end
    end

    // configuration word decode, held for the whole frame
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eng_size_log2 <= NFFT_MAX;
            eng_forward   <= fftc_pkg::DIR_FORWARD;
            eng_sched     <= '0;
            frame_last_q  <= '0;
        end else if (ce && cfg_hs) begin
            eng_size_log2 <= eff_size(s_axis_config_tdata);                        // see RULE3
            eng_forward   <= s_axis_config_tdata[fftc_pkg::CFG_DIR_BIT];           // see RULE4
            eng_sched     <= s_axis_config_tdata[fftc_pkg::CFG_SCH_LSB +: fftc_pkg::SCH_W]; // see RULE5
            // channels times 2^size beats; size is log2 of the point count
            frame_last_q  <= (CW'(fftc_pkg::CHANNELS) << eff_size(s_axis_config_tdata))
                             - CW'('h1);                                            // see RULE1
        end
    end

    // one-cycle start strobe follows the accepted configuration
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eng_start        <= 1'b0;
            ev_frame_started <= 1'b0;
        end else if (ce) begin
            eng_start        <= cfg_hs;
            ev_frame_started <= in_hs && (in_cnt_q == '0);
        end
    end

    // input register slice and beat counter; drop the pad bits toward the engine
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eng_in_valid <= 1'b0;
            eng_in_re    <= '0;
            eng_in_im    <= '0;
            in_cnt_q     <= '0;
        end else if (ce) begin
            if (in_hs) begin
                eng_in_valid <= 1'b1;                                               // see RULE10
                eng_in_re    <= s_axis_data_tdata[0 +: fftc_pkg::IN_W];             // see RULE12
                eng_in_im    <= s_axis_data_tdata[fftc_pkg::IN_PAD +: fftc_pkg::IN_W];
                in_cnt_q     <= in_final ? '0 : in_cnt_q + CW'('h1);
            end else if (eng_in_ready) begin
                eng_in_valid <= 1'b0;
            end
        end
    end

    // tlast checks: only flagged, the frame length from the config still rules
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ev_tlast_unexpected <= 1'b0;
            ev_tlast_missing    <= 1'b0;
        end else if (ce) begin
            ev_tlast_unexpected <= in_hs && s_axis_data_tlast && !in_final;
            ev_tlast_missing    <= in_hs && !s_axis_data_tlast && in_final;
        end
    end

    // widen each result component to whole bytes
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pad
            fftc_pad #(
                .W  (fftc_pkg::OUT_W),
                .PW (fftc_pkg::OUT_PAD)
            ) u_pad (
                .raw    ((gi == 0) ? eng_out_re : eng_out_im),
                .padded (out_pad[gi*fftc_pkg::OUT_PAD +: fftc_pkg::OUT_PAD])  // see RULE12
            );
        end
    endgenerate

    // output register slice with channel index and frame end marker
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_axis_data_tvalid <= 1'b0;
            m_axis_data_tdata  <= '0;
            m_axis_data_tuser  <= '0;
            m_axis_data_tlast  <= 1'b0;
            out_cnt_q          <= '0;
            out_ch_q           <= '0;
        end else if (ce) begin
            if (eout_hs) begin
                m_axis_data_tvalid <= 1'b1;                                         // see RULE10
                m_axis_data_tdata  <= out_pad;
                m_axis_data_tuser  <= out_ch_q;
                m_axis_data_tlast  <= out_final;
                out_cnt_q          <= out_final ? '0 : out_cnt_q + CW'('h1);
                // channel index runs fastest, sample index slower
                out_ch_q <= (out_final || out_ch_q == CH_LAST) ? '0
                            : out_ch_q + fftc_pkg::CH_W'('h1);                      // see RULE13
            end else if (m_axis_data_tready) begin
                m_axis_data_tvalid <= 1'b0;
            end
        end
    end

    // overflow gathered over the frame; a set in the clearing cycle still wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovf_q <= 1'b0;
            exp_q <= '0;
        end else if (ce) begin
            if (eout_hs && eng_out_overflow) ovf_q <= 1'b1;                          // see RULE7
            else if (cfg_hs) ovf_q <= 1'b0;
            if (eout_hs && out_final) exp_q <= eng_blk_exp;                          // see RULE8
        end
    end

    // status word latched as the last result leaves, held until taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat_q <= '0;
        end else if (ce && state_q == fftc_pkg::FFTC_DRAIN && mout_hs && m_axis_data_tlast) begin
            stat_q <= '0;
            stat_q[fftc_pkg::STAT_OVF_BIT]                      <= ovf_q;
            stat_q[fftc_pkg::STAT_EXP_LSB +: fftc_pkg::EXP_W]   <= exp_q;
        end
    end

    // checks
    property p_cfg_only_idle;
        @(posedge clk) disable iff (!resetn)
        s_axis_config_tready |-> !m_axis_status_tvalid && !m_axis_data_tvalid && !eng_in_valid;
    endproperty
    a_cfg_only_idle: assert property (p_cfg_only_idle) // see RULE16
        else $error("config taken outside idle");

    property p_size_used;
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_hs) |=> eng_start && eng_size_log2 == eff_size($past(s_axis_config_tdata));
    endproperty
    a_size_used: assert property (p_size_used) // see RULE3
        else $error("engine size differs from decoded config");

    property p_dir_sched;
        @(posedge clk) disable iff (!resetn)
        (ce && cfg_hs) |=> eng_forward == $past(s_axis_config_tdata[fftc_pkg::CFG_DIR_BIT])
            && eng_sched == $past(s_axis_config_tdata[fftc_pkg::CFG_SCH_LSB +: fftc_pkg::SCH_W]);
    endproperty
    a_dir_sched: assert property (p_dir_sched) // see RULE4
        else $error("direction or schedule not taken from config");

    property p_frame_len;
        @(posedge clk) disable iff (!resetn)
        eng_start |-> frame_last_q == (CW'(fftc_pkg::CHANNELS) << eng_size_log2) - CW'('h1);
    endproperty
    a_frame_len: assert property (p_frame_len) // see RULE1
        else $error("frame length not 2^size per channel");

    property p_status_after_last;
        @(posedge clk) disable iff (!resetn)
        (state_q == fftc_pkg::FFTC_DRAIN && mout_hs && m_axis_data_tlast)
            |=> m_axis_status_tvalid && m_axis_status_tdata[fftc_pkg::STAT_OVF_BIT] == $past(ovf_q);
    endproperty
    a_status_after_last: assert property (p_status_after_last) // see RULE7
        else $error("status missing or wrong after last result");

    property p_exp_in_status;
        @(posedge clk) disable iff (!resetn)
        m_axis_status_tvalid |->
            m_axis_status_tdata[fftc_pkg::STAT_EXP_LSB +: fftc_pkg::EXP_W] == exp_q;
    endproperty
    a_exp_in_status: assert property (p_exp_in_status) // see RULE8
        else $error("block exponent not in status");

    property p_out_stable;
        @(posedge clk) disable iff (!resetn)
        (m_axis_data_tvalid && !m_axis_data_tready)
            |=> m_axis_data_tvalid && $stable(m_axis_data_tdata) && $stable(m_axis_data_tlast);
    endproperty
    a_out_stable: assert property (p_out_stable) // see RULE10
        else $error("result stream changed while stalled");

    property p_pad_sign;
        @(posedge clk) disable iff (!resetn)
        m_axis_data_tvalid |-> m_axis_data_tdata[fftc_pkg::OUT_PAD-1]
                               == m_axis_data_tdata[fftc_pkg::OUT_W-1];
    endproperty
    a_pad_sign: assert property (p_pad_sign) // see RULE12
        else $error("pad bits do not copy the sign");

    property p_channel_first;
        @(posedge clk) disable iff (!resetn)
        (ce && eout_hs && !out_final)
            |=> out_ch_q == (($past(out_ch_q) == CH_LAST) ? '0
                             : $past(out_ch_q) + fftc_pkg::CH_W'('h1));
    endproperty
    a_channel_first: assert property (p_channel_first) // see RULE13
        else $error("channel index did not step first");

endmodule // fftc_wrap
`default_nettype wire

// ===== bench/fftc_eng_model.sv
// fftc_eng_model: behavioural transform engine that hands a whole frame back once gathered
`timescale 1ns/100ps
`default_nettype none
module fftc_eng_model (
    // clock, reset, stall control
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    // controls from the wrapper
    input  wire logic        eng_start,
    input  wire logic [4:0]  eng_size_log2,
    input  wire logic        eng_forward,
    input  wire logic [9:0]  eng_sched,
    // samples in
    input  wire logic        eng_in_valid,
    output logic             eng_in_ready,
    input  wire logic [15:0] eng_in_re,
    input  wire logic [15:0] eng_in_im,
    // results out
    output logic             eng_out_valid,
    input  wire logic        eng_out_ready,
    output logic [15:0]      eng_out_re,
    output logic [15:0]      eng_out_im,
    output logic             eng_out_overflow,
    output logic [4:0]       eng_blk_exp,
    // start count and what the last start carried
    output logic [7:0]       starts,
    output logic [4:0]       lat_size,
    output logic             lat_fwd,
    output logic [9:0]       lat_sched
);
    logic [15:0] re_m [0:1023];
    logic [15:0] im_m [0:1023];
    logic [10:0] n_in_q;
    logic [10:0] n_out_q;
    logic        stall_q;
    logic [10:0] len;
    logic [15:0] r_re;
    logic [15:0] r_im;

    // stall every other cycle when slow, so the wrapper must hold its beat
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) stall_q <= 1'b0;
        else stall_q <= slow & ~stall_q;
    end
    assign eng_in_ready = ~stall_q;

    // latch controls on start, then gather the frame and count results taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            n_in_q   <= 11'h000;
            n_out_q  <= 11'h000;
            starts   <= 8'h00;
            lat_size <= 5'h00;
            lat_fwd  <= 1'b0;
            lat_sched <= 10'h000;
        end else if (eng_start) begin
            n_in_q    <= 11'h000;
            n_out_q   <= 11'h000;
            starts    <= starts + 8'h01;
            lat_size  <= eng_size_log2;
            lat_fwd   <= eng_forward;
            lat_sched <= eng_sched;
        end else begin
            if (eng_in_valid && eng_in_ready && n_in_q != len) begin
                re_m[n_in_q[9:0]] <= eng_in_re;
                im_m[n_in_q[9:0]] <= eng_in_im;
                n_in_q <= n_in_q + 11'h001;
            end
            if (eng_out_valid && eng_out_ready) n_out_q <= n_out_q + 11'h001;
        end
    end

    // results only after the whole frame; idle lines show inverted data, not a stale beat
    assign len = 11'h001 << lat_size;
    assign eng_out_valid = (n_in_q == len) && (n_out_q != len);
    assign r_re = re_m[n_out_q[9:0]];
    assign r_im = im_m[n_out_q[9:0]];
    assign eng_out_re = (eng_out_valid && lat_fwd) ? r_re : ~r_re;
    assign eng_out_im = (eng_out_valid && lat_fwd) ? r_im : ~r_im;
    assign eng_out_overflow = eng_out_valid && (r_re == 16'h8000);
    assign eng_blk_exp = lat_sched[4:0];
endmodule // fftc_eng_model
`default_nettype wire

// ===== bench/testbench.sv
// testbench: frames of several sizes, directions and stalls through wrapper and engine model
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1, slow = 1'b0;
    logic        cfg_v = 1'b0, cfg_r;
    logic [23:0] cfg_d = 24'h000000;
    logic        in_v = 1'b0, in_r, in_l = 1'b0;
    logic [31:0] in_d = 32'h00000000;
    logic        m_v, m_r = 1'b0, m_l, st_v, st_r = 1'b0;
    logic [31:0] m_d;
    logic [3:0]  m_u;
    logic [7:0]  st_d, starts;
    logic        e_st, e_sz_f, e_v, e_r, o_v, o_r, o_ovf, lat_fwd, ev_fs, ev_tu, ev_tm;
    logic [4:0]  e_sz, o_exp, lat_size;
    logic [9:0]  e_sch, lat_sched;
    logic [15:0] e_re, e_im, o_re, o_im;
    int          fail_count = 0, comparisons = 0, n_fs = 0, n_tu = 0, n_tm = 0;

    always #5 clk = ~clk;
    // result side stalls every other cycle while slow
    always @(negedge clk) m_r <= slow ? ~m_r : 1'b1;
    // event pulse counters
    always @(posedge clk) begin
        n_fs <= n_fs + int'(ev_fs === 1'b1);
        n_tu <= n_tu + int'(ev_tu === 1'b1);
        n_tm <= n_tm + int'(ev_tm === 1'b1);
    end

    fftc_wrap dut_u (.clk(clk), .resetn(resetn), .ce(ce),
        .s_axis_config_tvalid(cfg_v), .s_axis_config_tready(cfg_r), .s_axis_config_tdata(cfg_d),
        .s_axis_data_tvalid(in_v), .s_axis_data_tready(in_r), .s_axis_data_tdata(in_d),
        .s_axis_data_tlast(in_l), .m_axis_data_tvalid(m_v), .m_axis_data_tready(m_r),
        .m_axis_data_tdata(m_d), .m_axis_data_tuser(m_u), .m_axis_data_tlast(m_l),
        .m_axis_status_tvalid(st_v), .m_axis_status_tready(st_r), .m_axis_status_tdata(st_d),
        .eng_start(e_st), .eng_size_log2(e_sz), .eng_forward(e_sz_f), .eng_sched(e_sch),
        .eng_in_valid(e_v), .eng_in_ready(e_r), .eng_in_re(e_re), .eng_in_im(e_im),
        .eng_out_valid(o_v), .eng_out_ready(o_r), .eng_out_re(o_re), .eng_out_im(o_im),
        .eng_out_overflow(o_ovf), .eng_blk_exp(o_exp), .ev_frame_started(ev_fs),
        .ev_tlast_unexpected(ev_tu), .ev_tlast_missing(ev_tm));
    fftc_eng_model eng_u (.clk(clk), .resetn(resetn), .slow(slow), .eng_start(e_st),
        .eng_size_log2(e_sz), .eng_forward(e_sz_f), .eng_sched(e_sch), .eng_in_valid(e_v),
        .eng_in_ready(e_r), .eng_in_re(e_re), .eng_in_im(e_im), .eng_out_valid(o_v),
        .eng_out_ready(o_r), .eng_out_re(o_re), .eng_out_im(o_im), .eng_out_overflow(o_ovf),
        .eng_blk_exp(o_exp), .starts(starts), .lat_size(lat_size), .lat_fwd(lat_fwd),
        .lat_sched(lat_sched));

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // input pattern; the chosen beat carries the value that makes the engine overflow
    function automatic logic [31:0] smp(input int i, input int ob);
        logic [15:0] r;
        r = (i == ob) ? 16'h8000 : 16'h1000 + 16'(i * 7);
        smp = {~r ^ 16'h00ff, r};
    endfunction

    task automatic send_config(input logic [4:0] sz, input logic dir, input logic [9:0] sch);
        @(negedge clk);
        cfg_v = 1'b1;
        cfg_d = {5'h00, sch, dir, 3'h0, sz};
        do @(posedge clk); while (cfg_r !== 1'b1);
        @(negedge clk);
        cfg_v = 1'b0;
        cfg_d = ~cfg_d;
    endtask

    task automatic send_data(input int n, input int ob, input int tl);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            in_v = 1'b1;
            in_d = smp(i, ob);
            in_l = (i == tl);
            do @(posedge clk); while (in_r !== 1'b1);
        end
        @(negedge clk);
        in_v = 1'b0;
        in_l = 1'b0;
        in_d = ~in_d;
    endtask

    task automatic collect(input int n, input logic fwd, input int ob);
        logic [31:0] e;
        for (int i = 0; i < n; i++) begin
            do @(posedge clk); while (!(m_v === 1'b1 && m_r === 1'b1));
            e = fwd ? smp(i, ob) : ~smp(i, ob);
            check({3'h0, m_l, m_u, m_d}, {3'h0, 1'(i == n - 1), 4'h0, e});
        end
    endtask

    task automatic run_frame(input logic [4:0] sz, input logic dir, input logic [9:0] sch,
                             input int ob, input int tl);
        int n, s0, fs0, tu0, tm0;
        n = 1 << sz;
        s0 = int'(starts);
        fs0 = n_fs;
        tu0 = n_tu;
        tm0 = n_tm;
        send_config(sz, dir, sch);
        check(40'(cfg_r), 40'h0);
        fork
            send_data(n, ob, tl);
            collect(n, dir, ob);
        join
        repeat (2) @(negedge clk);
        check(40'(st_v), 40'h1);
        st_r = 1'b1;
        @(posedge clk);
        check({32'h0, st_d}, {32'h0, 2'b00, sch[4:0], 1'(ob < n)});
        @(negedge clk);
        st_r = 1'b0;
        check(40'(int'(starts) - s0), 40'h1);
        check({34'h0, lat_fwd, lat_size}, {34'h0, dir, sz});
        check(40'(lat_sched), 40'(sch));
        check(40'(n_fs - fs0), 40'h1);
        check(40'({n_tu - tu0, n_tm - tm0}), 40'({32'(tl != n - 1), 32'(tl != n - 1)}));
        @(negedge clk);
        check(40'(cfg_r), 40'h1);
        $display("test done: size %0d direction %0d", sz, dir);
    endtask

    task automatic stop_test;
        $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog: the frames need about 2200 cycles
    initial begin
        #300000;
        fail_count++;
        stop_test;
    end

    initial begin
        repeat (8) @(negedge clk);
        check(40'({cfg_r, m_v, st_v}), 40'h4);
        resetn = 1'b1;
        @(negedge clk);
        ce = 1'b0;
        #1 check(40'(cfg_r), 40'h0);
        @(negedge clk);
        ce = 1'b1;
        run_frame(5'd3, 1'b1, 10'h2ab, 99, 7);
        slow = 1'b1;
        run_frame(5'd4, 1'b0, 10'h155, 5, 15);
        slow = 1'b0;
        run_frame(5'd3, 1'b1, 10'h01f, 99, 0);
        run_frame(5'd10, 1'b1, 10'h3ff, 1023, 1023);
        stop_test;
    end
endmodule // testbench
`default_nettype wire
